//--- rtl/transceiver_status_mode_regs.v
// Live status and operating configuration registers behind a serial control port.
`timescale 1ns/10ps
`include "transceiver_status_mode_regs_regs.vh"

// Operation
// - Status bit 7 follows thermal shutdown, high while in shutdown.
// - Status bit 6 follows the auxiliary digital input level.
// - Status bit 5 follows the auxiliary output driver fault.
// - Status bit 4 follows the main line driver fault.
// - Status bit 3 high while supply is below the low-voltage warning level.
// - Status bit 2 high while supply is below undervoltage lockout.
// - Status bit 1 follows the main communication line level.
// - Status bit 0 sets above temperature warning, clears below warning minus hysteresis.
// - Status is read-only, live, unaffected by reads, zero after reset.
// - Writing configuration bit 7 as 1 restores all registers and drops the interrupt.
// - No interrupts are generated while the register reset bit is 1.
// - Configuration bit 6 set disables wake-up detection on the line.
// - Configuration bit 5 set turns the 3.3V regulator enable inactive.
// - Configuration bit 4 set routes UART signals onto the serial pins.
// - Configuration bit 3 set enables the supply warning interrupt flag.
// - Configuration bit 2 set bypasses the receive deglitch filter.
// - Configuration bit 1 directly sets the second indicator level.
// - Configuration bit 0 forces indicator one high, else it follows its input.
// - Configuration register is read-write, zero after reset, unchanged by reads.
// - Interrupt output asserts on any latched bit; reading latches clears them.
module transceiver_status_mode_regs (
  input wire CLOCK,
  input wire NRST,
  input wire THERMAL_SHUTDOWN,
  input wire AUX_INPUT_PIN,
  input wire AUX_OUTPUT_FAULT,
  input wire LINE_DRIVER_FAULT,
  input wire SUPPLY_LOW,
  input wire SUPPLY_UNDERVOLTAGE,
  input wire LINE_LEVEL,
  input wire TEMP_ABOVE_WARN,
  input wire TEMP_BELOW_HYST,
  input wire WAKEUP_REQUEST,
  input wire INDICATOR1_INPUT,
  input wire SCLK,
  input wire CS_N,
  input wire MOSI,
  output reg MISO,
  output reg MISO_OE_N,
  output reg INTERRUPT_OUT_N,
  output reg WAKEUP_DETECT_EN,
  output reg LOW_REGULATOR_EN,
  output reg SERIAL_MUX_EN,
  output reg LINE_FILTER_BYPASS,
  output reg INDICATOR2,
  output reg INDICATOR1
);

  // ==========================================================================
  // Input synchronisers
  wire [`NUM_SYNC_INPUTS-1:0] raw_in;
  reg [`NUM_SYNC_INPUTS-1:0] sync1_reg;
  reg [`NUM_SYNC_INPUTS-1:0] sync2_reg;
  reg sclk_prev_reg;
  reg wake_prev_reg;

  assign raw_in = {THERMAL_SHUTDOWN, AUX_INPUT_PIN, AUX_OUTPUT_FAULT, LINE_DRIVER_FAULT,
                   SUPPLY_LOW, SUPPLY_UNDERVOLTAGE, LINE_LEVEL, TEMP_ABOVE_WARN,
                   TEMP_BELOW_HYST, WAKEUP_REQUEST, INDICATOR1_INPUT, SCLK, CS_N};

  // Stage one is read only by stage two; chip select resets to its idle high level
  // so the data pin is not driven for two cycles after reset release
  always @(posedge CLOCK) begin
    if (!NRST) begin
      sync1_reg <= {{(`NUM_SYNC_INPUTS-1){1'b0}}, 1'b1};
      sync2_reg <= {{(`NUM_SYNC_INPUTS-1){1'b0}}, 1'b1};
    end else begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
    end
  end

  wire s_thermal = sync2_reg[12];
  wire s_aux_in = sync2_reg[11];
  wire s_aux_fault = sync2_reg[10];
  wire s_line_fault = sync2_reg[9];
  wire s_supply_low = sync2_reg[8];
  wire s_supply_uv = sync2_reg[7];
  wire s_line_level = sync2_reg[6];
  wire s_temp_above = sync2_reg[5];
  wire s_temp_below = sync2_reg[4];
  wire s_wake = sync2_reg[3];
  wire s_ind1_in = sync2_reg[2];
  wire s_sclk = sync2_reg[1];
  wire s_cs_n = sync2_reg[0];

  // MOSI has its own pair so it stays aligned with the clock edge it is taken on
  reg mosi1_reg;
  reg mosi2_reg;
  always @(posedge CLOCK) begin
    if (!NRST) begin
      mosi1_reg <= 1'b0;
      mosi2_reg <= 1'b0;
    end else begin
      mosi1_reg <= MOSI;
      mosi2_reg <= mosi1_reg;
    end
  end

  // ==========================================================================
  // Registers and soft reset
  reg [7:0] status_reg;
  reg [7:0] status_prev_reg;
  reg [7:0] irq_latch_reg;
  reg [7:0] config_reg;
  reg temp_warn_reg;
  wire soft_reset = config_reg[`CF_REGISTER_RESET];
  wire clear_all = !NRST || soft_reset;

  // Hysteresis: only the lower threshold clears the warning
  always @(posedge CLOCK) begin
    if (clear_all) begin
      temp_warn_reg <= 1'b0;
    end else if (s_temp_above) begin
      temp_warn_reg <= 1'b1;
    end else if (s_temp_below) begin
      temp_warn_reg <= 1'b0;
    end
  end

  // Live view, rebuilt every cycle; reads never touch it
  always @(posedge CLOCK) begin
    if (clear_all) begin
      status_reg <= `RST_LIVE_STATUS;
      status_prev_reg <= `RST_LIVE_STATUS;
      wake_prev_reg <= 1'b0;
    end else begin
      status_reg[`ST_THERMAL_SHUTDOWN] <= s_thermal;
      status_reg[`ST_AUX_INPUT_LEVEL] <= s_aux_in;
      status_reg[`ST_AUX_OUTPUT_FAULT] <= s_aux_fault;
      status_reg[`ST_LINE_DRIVER_FAULT] <= s_line_fault;
      status_reg[`ST_SUPPLY_LOW_WARNING] <= s_supply_low;
      status_reg[`ST_SUPPLY_UNDERVOLTAGE] <= s_supply_uv;
      status_reg[`ST_LINE_LEVEL] <= s_line_level;
      status_reg[`ST_OVERTEMP_WARNING] <= temp_warn_reg;
      status_prev_reg <= status_reg;
      wake_prev_reg <= s_wake;
    end
  end

  // Rising conditions that latch an interrupt; level-only bits never latch
  reg [7:0] irq_set;
  always @* begin
    irq_set = 8'h00;
    irq_set[`ST_THERMAL_SHUTDOWN] = status_reg[`ST_THERMAL_SHUTDOWN] &
                                    ~status_prev_reg[`ST_THERMAL_SHUTDOWN];
    irq_set[`ST_AUX_OUTPUT_FAULT] = status_reg[`ST_AUX_OUTPUT_FAULT] &
                                    ~status_prev_reg[`ST_AUX_OUTPUT_FAULT];
    irq_set[`ST_LINE_DRIVER_FAULT] = status_reg[`ST_LINE_DRIVER_FAULT] &
                                     ~status_prev_reg[`ST_LINE_DRIVER_FAULT];
    irq_set[`ST_SUPPLY_LOW_WARNING] = status_reg[`ST_SUPPLY_LOW_WARNING] &
                                      ~status_prev_reg[`ST_SUPPLY_LOW_WARNING] &
                                      config_reg[`CF_SUPPLY_WARNING_IRQ_ENABLE];
    irq_set[`ST_SUPPLY_UNDERVOLTAGE] = status_reg[`ST_SUPPLY_UNDERVOLTAGE] &
                                       ~status_prev_reg[`ST_SUPPLY_UNDERVOLTAGE];
    irq_set[`ST_OVERTEMP_WARNING] = status_reg[`ST_OVERTEMP_WARNING] &
                                    ~status_prev_reg[`ST_OVERTEMP_WARNING];
    irq_set[`IRQ_WAKEUP] = s_wake & ~wake_prev_reg &
                           ~config_reg[`CF_WAKEUP_DETECT_DISABLE];
  end

  // ==========================================================================
  // Serial control port, mode 0, MSB first
  reg [4:0] bit_cnt_reg;
  reg [7:0] rx_shift_reg;
  reg [7:0] cmd_reg;
  reg [7:0] tx_shift_reg;
  wire sclk_rise = s_sclk & ~sclk_prev_reg;
  wire sclk_fall = ~s_sclk & sclk_prev_reg;
  wire [7:0] rx_next = {rx_shift_reg[6:0], mosi2_reg};
  wire cmd_done = sclk_rise && !s_cs_n && (bit_cnt_reg == {1'b0, `CMD_BITS} - 5'h01);
  wire frame_done = sclk_rise && !s_cs_n && (bit_cnt_reg == `FRAME_BITS - 5'h01);
  wire [2:0] cmd_addr = rx_next[2:0];
  wire cmd_is_write = rx_next[`FRAME_WRITE_BIT];
  wire irq_read = cmd_done && !cmd_is_write && (cmd_addr == `ADDR_IRQ_LATCH);
  wire cfg_write = frame_done && cmd_reg[`FRAME_WRITE_BIT] &&
                   (cmd_reg[2:0] == `ADDR_OP_CONFIG);

  function [7:0] read_mux;
    input [2:0] addr;
    input [7:0] irq_v;
    input [7:0] st_v;
    input [7:0] cf_v;
    begin
      case (addr)
        `ADDR_IRQ_LATCH: read_mux = irq_v;
        `ADDR_LIVE_STATUS: read_mux = st_v;
        `ADDR_OP_CONFIG: read_mux = cf_v;
        default: read_mux = 8'h00;
      endcase
    end
  endfunction

  always @(posedge CLOCK) begin
    if (!NRST) begin
      sclk_prev_reg <= 1'b0;
      bit_cnt_reg <= 5'h00;
      rx_shift_reg <= 8'h00;
      cmd_reg <= 8'h00;
      tx_shift_reg <= 8'h00;
      MISO <= 1'b0;
      MISO_OE_N <= 1'b1;
    end else begin
      sclk_prev_reg <= s_sclk;
      MISO_OE_N <= s_cs_n;
      if (s_cs_n) begin
        bit_cnt_reg <= 5'h00;
        MISO <= 1'b0;
      end else begin
        if (sclk_rise) begin
          rx_shift_reg <= rx_next;
          bit_cnt_reg <= frame_done ? 5'h00 : bit_cnt_reg + 5'h01;
          if (cmd_done) begin
            cmd_reg <= rx_next;
            // Reads have no side effect except on the latched interrupt register
            tx_shift_reg <= cmd_is_write ? 8'h00 :
                            read_mux(cmd_addr, irq_latch_reg, status_reg, config_reg);
          end
        end
        if (sclk_fall && (bit_cnt_reg > {1'b0, `CMD_BITS} - 5'h01)) begin
          MISO <= tx_shift_reg[7];
          tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
        end
      end
    end
  end

  // ==========================================================================
  // Latched interrupts and configuration
  always @(posedge CLOCK) begin
    if (clear_all) begin
      irq_latch_reg <= `RST_IRQ_LATCH;
    end else begin
      // A new event in the clearing cycle survives the read
      irq_latch_reg <= (irq_read ? 8'h00 : irq_latch_reg) | irq_set;
    end
  end

  // The reset bit lives one cycle: it clears the status, latch and configuration registers, itself included; the serial port keeps its state
  always @(posedge CLOCK) begin
    if (clear_all) begin
      config_reg <= `RST_OP_CONFIG;
    end else if (cfg_write) begin
      config_reg <= rx_next;
    end
  end

  // ==========================================================================
  // Outputs, all registered
  always @(posedge CLOCK) begin
    if (!NRST) begin
      INTERRUPT_OUT_N <= 1'b1;
      WAKEUP_DETECT_EN <= 1'b1;
      LOW_REGULATOR_EN <= 1'b1;
      SERIAL_MUX_EN <= 1'b0;
      LINE_FILTER_BYPASS <= 1'b0;
      INDICATOR2 <= 1'b0;
      INDICATOR1 <= 1'b0;
    end else begin
      INTERRUPT_OUT_N <= soft_reset | ~(|irq_latch_reg);
      WAKEUP_DETECT_EN <= ~config_reg[`CF_WAKEUP_DETECT_DISABLE];
      LOW_REGULATOR_EN <= ~config_reg[`CF_LOW_REGULATOR_DISABLE];
      SERIAL_MUX_EN <= config_reg[`CF_SERIAL_MUX_ENABLE];
      LINE_FILTER_BYPASS <= config_reg[`CF_LINE_FILTER_BYPASS];
      INDICATOR2 <= config_reg[`CF_INDICATOR2_LEVEL];
      INDICATOR1 <= config_reg[`CF_INDICATOR1_SELECT] | s_ind1_in;
    end
  end

endmodule

//--- rtl/transceiver_status_mode_regs_regs.vh
// Register offsets, field positions, reset values and serial frame constants.
`ifndef TRANSCEIVER_STATUS_MODE_REGS_REGS_VH
`define TRANSCEIVER_STATUS_MODE_REGS_REGS_VH

// ==========================================================================
// Register offsets (3-bit address field of the serial frame)
`define ADDR_IRQ_LATCH 3'h0
`define ADDR_LIVE_STATUS 3'h1
`define ADDR_OP_CONFIG 3'h2

// ==========================================================================
// Status and latched interrupt field positions
`define ST_THERMAL_SHUTDOWN 7
`define ST_AUX_INPUT_LEVEL 6
`define ST_AUX_OUTPUT_FAULT 5
`define ST_LINE_DRIVER_FAULT 4
`define ST_SUPPLY_LOW_WARNING 3
`define ST_SUPPLY_UNDERVOLTAGE 2
`define ST_LINE_LEVEL 1
`define ST_OVERTEMP_WARNING 0
`define IRQ_WAKEUP 6

// ==========================================================================
// Configuration field positions
`define CF_REGISTER_RESET 7
`define CF_WAKEUP_DETECT_DISABLE 6
`define CF_LOW_REGULATOR_DISABLE 5
`define CF_SERIAL_MUX_ENABLE 4
`define CF_SUPPLY_WARNING_IRQ_ENABLE 3
`define CF_LINE_FILTER_BYPASS 2
`define CF_INDICATOR2_LEVEL 1
`define CF_INDICATOR1_SELECT 0

// ==========================================================================
// Reset values
`define RST_IRQ_LATCH 8'h00
`define RST_LIVE_STATUS 8'h00
`define RST_OP_CONFIG 8'h00

// ==========================================================================
// Serial frame: command byte then data byte, MSB first
`define FRAME_WRITE_BIT 7
`define CMD_BITS 4'h8
`define FRAME_BITS 5'h10
`define NUM_SYNC_INPUTS 13

`endif

//--- test/status_mode_checker.sv
// Port-level assertions for the status and configuration register block.
`timescale 1ns/10ps
module status_mode_checker (
  input wire CLOCK,
  input wire NRST,
  input wire THERMAL_SHUTDOWN,
  input wire LINE_DRIVER_FAULT,
  input wire INDICATOR1_INPUT,
  input wire CS_N,
  input wire MISO_OE_N,
  input wire INTERRUPT_OUT_N,
  input wire WAKEUP_DETECT_EN,
  input wire LOW_REGULATOR_EN,
  input wire SERIAL_MUX_EN,
  input wire LINE_FILTER_BYPASS,
  input wire INDICATOR2,
  input wire INDICATOR1
);
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!NRST);
  // ==========================================================================
  // Serial port, configuration pins and interrupt
  chk_oe_on_select: assert property ($fell(CS_N) |-> ##3 !MISO_OE_N)
    else $error("output enable late after select");
  chk_reset_values: assert property ($rose(NRST) |-> INTERRUPT_OUT_N && MISO_OE_N
    && WAKEUP_DETECT_EN && LOW_REGULATOR_EN && !SERIAL_MUX_EN && !LINE_FILTER_BYPASS
    && !INDICATOR2 && !INDICATOR1) else $error("pins wrong after reset");
  // Config pins may only move while a frame is in flight or just after
  chk_cfg_idle_stable: assert property (CS_N [*8] |=> $stable({WAKEUP_DETECT_EN,
    LOW_REGULATOR_EN, SERIAL_MUX_EN, LINE_FILTER_BYPASS, INDICATOR2})) else $error("cfg moved");
  chk_ind1_low: assert property (!INDICATOR1 |-> !$past(INDICATOR1_INPUT, 3))
    else $error("indicator one low while input high");
  chk_ind1_high: assert property ($past(INDICATOR1_INPUT, 3) |-> INDICATOR1)
    else $error("indicator one not following input");
  chk_irq_thermal: assert property ($rose(THERMAL_SHUTDOWN) && CS_N
    |-> ##[2:10] !INTERRUPT_OUT_N) else $error("no interrupt on thermal event");
  chk_irq_line_fault: assert property ($rose(LINE_DRIVER_FAULT) && CS_N
    |-> ##[2:10] !INTERRUPT_OUT_N) else $error("no interrupt on line fault");
  chk_irq_held: assert property (!INTERRUPT_OUT_N && CS_N |=> !INTERRUPT_OUT_N)
    else $error("interrupt dropped without access");
  // ==========================================================================
  // Coverage
  cover property ($fell(INTERRUPT_OUT_N));
  cover property ($rose(INTERRUPT_OUT_N));
  cover property ($rose(SERIAL_MUX_EN));
endmodule
bind transceiver_status_mode_regs status_mode_checker u_status_mode_checker (.CLOCK(CLOCK),
  .NRST(NRST), .THERMAL_SHUTDOWN(THERMAL_SHUTDOWN), .LINE_DRIVER_FAULT(LINE_DRIVER_FAULT),
  .INDICATOR1_INPUT(INDICATOR1_INPUT), .CS_N(CS_N), .MISO_OE_N(MISO_OE_N),
  .INTERRUPT_OUT_N(INTERRUPT_OUT_N), .WAKEUP_DETECT_EN(WAKEUP_DETECT_EN),
  .LOW_REGULATOR_EN(LOW_REGULATOR_EN), .SERIAL_MUX_EN(SERIAL_MUX_EN),
  .LINE_FILTER_BYPASS(LINE_FILTER_BYPASS), .INDICATOR2(INDICATOR2), .INDICATOR1(INDICATOR1));

//--- test/host_model.sv
// Host controller model driving the serial register port.
`timescale 1ns/10ps
module host_model (
  input wire CLOCK,
  input wire MISO,
  output logic SCLK,
  output logic CS_N,
  output logic MOSI
);
  initial begin
    SCLK = 1'b0;
    CS_N = 1'b1;
    MOSI = 1'b0;
  end
  // Five clocks per half period, since the port only samples the serial clock
  task automatic xfer(input logic [15:0] frame, output logic [7:0] rd);
    int i;
    CS_N = 1'b0;
    repeat (5) @(negedge CLOCK);
    for (i = 15; i >= 0; i--) begin
      MOSI = frame[i];
      repeat (5) @(negedge CLOCK);
      if (i < 8) rd[i] = MISO;
      SCLK = 1'b1;
      repeat (5) @(negedge CLOCK);
      SCLK = 1'b0;
    end
    repeat (5) @(negedge CLOCK);
    CS_N = 1'b1;
    repeat (10) @(negedge CLOCK);
  endtask
endmodule

//--- test/testbench.sv
// Self-checking bench for the status and configuration registers.
`timescale 1ns/10ps
`include "transceiver_status_mode_regs_regs.vh"
module testbench;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] cond = 8'h00;
  logic hyst = 1'b0;
  logic wake = 1'b0;
  logic ind1_in = 1'b0;
  wire sclk, cs_n, mosi, miso, irq_n;
  wire [5:0] pins;
  int num_errors = 0;
  int checks = 0;
  int cycles = 0;
  logic [7:0] v;
  always #50 clock = ~clock;
  transceiver_status_mode_regs u_transceiver_status_mode_regs (.CLOCK(clock), .NRST(nrst),
    .THERMAL_SHUTDOWN(cond[7]), .AUX_INPUT_PIN(cond[6]), .AUX_OUTPUT_FAULT(cond[5]),
    .LINE_DRIVER_FAULT(cond[4]), .SUPPLY_LOW(cond[3]), .SUPPLY_UNDERVOLTAGE(cond[2]),
    .LINE_LEVEL(cond[1]), .TEMP_ABOVE_WARN(cond[0]), .TEMP_BELOW_HYST(hyst),
    .WAKEUP_REQUEST(wake), .INDICATOR1_INPUT(ind1_in), .SCLK(sclk), .CS_N(cs_n), .MOSI(mosi),
    .MISO(miso), .MISO_OE_N(), .INTERRUPT_OUT_N(irq_n), .WAKEUP_DETECT_EN(pins[5]),
    .LOW_REGULATOR_EN(pins[4]), .SERIAL_MUX_EN(pins[3]), .LINE_FILTER_BYPASS(pins[2]),
    .INDICATOR2(pins[1]), .INDICATOR1(pins[0]));
  host_model u_host_model (.CLOCK(clock), .MISO(miso), .SCLK(sclk), .CS_N(cs_n), .MOSI(mosi));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [2:0] a);
    u_host_model.xfer({5'h00, a, 8'h00}, v);
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    logic [7:0] x;
    u_host_model.xfer({5'h10, a, d}, x);
  endtask
  task automatic wt;
    repeat (6) @(negedge clock);
  endtask
  task automatic summarize;
    $display("errors=%0d checks=%0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_status;
    int i;
    rd(`ADDR_LIVE_STATUS); check(v, `RST_LIVE_STATUS);
    cond = 8'h01; wt; rd(`ADDR_LIVE_STATUS); check(v, 8'h01);
    cond = 8'h00; wt; rd(`ADDR_LIVE_STATUS); check(v, 8'h01);
    hyst = 1'b1; wt; rd(`ADDR_LIVE_STATUS); check(v, 8'h00);
    hyst = 1'b0;
    for (i = 1; i < 8; i++) begin
      cond = 8'h01 << i; wt; rd(`ADDR_LIVE_STATUS); check(v, cond);
    end
    rd(`ADDR_LIVE_STATUS); check(v, 8'h80);
    cond = 8'h00; wr(`ADDR_LIVE_STATUS, 8'hFF); rd(`ADDR_LIVE_STATUS); check(v, 8'h00);
  endtask
  task automatic t_config;
    rd(`ADDR_OP_CONFIG); check(v, `RST_OP_CONFIG);
    wr(`ADDR_OP_CONFIG, 8'h7F); rd(`ADDR_OP_CONFIG); check(v, 8'h7F);
    check({2'b00, pins}, 8'h0F);
    wr(`ADDR_OP_CONFIG, 8'h00); ind1_in = 1'b1; wt; check({2'b00, pins}, 8'h31);
    ind1_in = 1'b0; wt; check({2'b00, pins}, 8'h30);
  endtask
  task automatic t_irq;
    rd(`ADDR_IRQ_LATCH);
    cond = 8'h80; wt; cond = 8'h00; wt; check({7'h00, irq_n}, 8'h00);
    rd(`ADDR_IRQ_LATCH); check(v, 8'h80);
    check({7'h00, irq_n}, 8'h01);
    cond = 8'h08; wt; cond = 8'h00; rd(`ADDR_IRQ_LATCH); check(v, 8'h00);
    wr(`ADDR_OP_CONFIG, 8'h08); cond = 8'h08; wt; cond = 8'h00;
    rd(`ADDR_IRQ_LATCH); check(v, 8'h08);
    wr(`ADDR_OP_CONFIG, 8'h40); wake = 1'b1; wt; wake = 1'b0;
    rd(`ADDR_IRQ_LATCH); check(v, 8'h00);
    wr(`ADDR_OP_CONFIG, 8'h00); wake = 1'b1; wt; wake = 1'b0;
    rd(`ADDR_IRQ_LATCH); check(v, 8'h40);
  endtask
  task automatic t_soft;
    wr(`ADDR_OP_CONFIG, 8'h2F); cond = 8'h10; wt; cond = 8'h00; wt;
    wr(`ADDR_OP_CONFIG, 8'h80); rd(`ADDR_OP_CONFIG); check(v, 8'h00);
    check({1'b0, irq_n, pins}, 8'h70);
    rd(`ADDR_IRQ_LATCH); check(v, 8'h00);
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      summarize;
    end
  end
  initial begin
    repeat (12) @(negedge clock);
    nrst = 1'b1;
    t_status;
    t_config;
    t_irq;
    t_soft;
    summarize;
  end
endmodule
